// >>> pkg/pic_pkg.sv
// pic_pkg: register indices, field positions and constants for pic_top.
// assumes byte address = 4 * register index on the axi4-lite bus.
package pic_pkg;
  // ------------------------------------------------------------
  // register indices (byte address = index * 4)
  // ------------------------------------------------------------
  localparam logic [7:0] IX_IE    = 8'ha8;
  localparam logic [7:0] IX_IE2   = 8'haf;
  localparam logic [7:0] IX_IP2   = 8'hb5;
  localparam logic [7:0] IX_IP    = 8'hb8;
  localparam logic [7:0] IX_SPS   = 8'hcd;
  localparam logic [7:0] IX_SPCTL = 8'hce;
  localparam logic [7:0] IX_COUNTER_CTRL_REG  = 8'hd8;
  localparam logic [7:0] IX_COUNTER_MODE  = 8'hd9;
  localparam logic [7:0] IX_CM0   = 8'hda;
  localparam logic [7:0] IX_CM1   = 8'hdb;
  localparam logic [7:0] IX_STAT  = 8'hf0;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int B_EA   = 7;
  localparam int B_SERIAL_PERIPH_IRQ_EN = 1;
  localparam int B_ES2  = 0;
  localparam int B_XFER_DONE_FLAG = 7;
  localparam int B_WRITE_CLASH_FLAG = 6;
  localparam int B_SELECT_IGNORE = 7;
  localparam int B_CF   = 7;
  localparam int B_ECF  = 0;
  localparam int B_MAT  = 3;
  localparam int B_ECCF = 0;
  localparam int N_IE_SRC = 7;
  // ------------------------------------------------------------
  // sources, vectors, resets, responses
  // ------------------------------------------------------------
  localparam int NSRC    = 24;
  localparam int SRC_X0  = 0;
  localparam int SRC_X1  = 2;
  localparam int SRC_PCA = 7;
  localparam int SRC_S2  = 8;
  localparam int SRC_SPI = 9;
  localparam int SRC_X4  = 16;
  localparam int SRC_PWM = 22;
  localparam int SRC_PFD = 23;
  localparam logic [23:0] SRC_UNUSED = 24'h00e000;
  localparam logic [15:0] VEC_BASE   = 16'h0003;
  localparam int          VEC_SHIFT  = 3;
  localparam logic [7:0]  REG_RST    = 8'h00;
  localparam logic [1:0]  RESP_OKAY  = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
endpackage

// >>> rtl/pic_top.sv
// pic_top: two-level prioritised interrupt controller with axi4-lite registers.
// assumes a core that flags opcode-fetch and last-cycle and performs the call itself.
`timescale 1ns/1ps
module pic_top
  import pic_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              aclk,          // system clock
  input  wire logic              aresetn,       // sync reset, low
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,  // write address
  input  wire logic              s_axi_awvalid, // write address valid
  output logic                   s_axi_awready, // write address ready
  input  wire logic [31:0]       s_axi_wdata,   // write data
  input  wire logic [3:0]        s_axi_wstrb,   // write strobes
  input  wire logic              s_axi_wvalid,  // write data valid
  output logic                   s_axi_wready,  // write data ready
  output logic [1:0]             s_axi_bresp,   // write response
  output logic                   s_axi_bvalid,  // write response valid
  input  wire logic              s_axi_bready,  // write response ready
  input  wire logic [ADDR_W-1:0] s_axi_araddr,  // read address
  input  wire logic              s_axi_arvalid, // read address valid
  output logic                   s_axi_arready, // read address ready
  output logic [31:0]            s_axi_rdata,   // read data
  output logic [1:0]             s_axi_rresp,   // read response
  output logic                   s_axi_rvalid,  // read data valid
  input  wire logic              s_axi_rready,  // read data ready
  input  wire logic              opfetch,       // opcode fetch cycle
  input  wire logic              last_cycle,    // final clock of instruction
  input  wire logic              instr_return_from_irq,    // return_from_irq executing
  input  wire logic              instr_cfg_wr,  // instr writes enable/priority
  input  wire logic              isp_active,    // in_system_programming busy
  input  wire logic [NSRC-1:0]   src_req,       // peripheral request flags
  input  wire logic [1:0]        ext_edge,      // ext0/ext1 edge mode
  input  wire logic              spi_done,      // serial transfer finished
  input  wire logic              spi_master,    // serial iface master mode
  input  wire logic              ss_is_input,   // select pin is input
  input  wire logic              ss_pin,        // select pin level (async)
  input  wire logic              serial_data_reg_wr,      // serial_data_reg written
  input  wire logic              spi_busy,      // transfer in progress
  input  wire logic              cnt_wrap,      // array counter wrapped
  input  wire logic [1:0]        cmp_hit,       // counter matched module
  input  wire logic [1:0]        cap_evt,       // module capture event
  output logic                   call_r,        // hardware long_call pulse
  output logic [15:0]            call_vec_r,    // vector address
  output logic [4:0]             call_num_r,    // interrupt number
  output logic [1:0]             ext_clr_r,     // clear ext0/ext1 request
  output logic [1:0]             in_prog_r,     // {high, low} in progress
  output logic                   xfer_irq_r     // serial iface request
);
  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  // lowest-numbered set bit wins within a level
  function automatic logic [4:0] pick(input logic [NSRC-1:0] v);
    logic [4:0] n;
    n = 5'h00;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        n = i[4:0];
      end
    end
    return n;
  endfunction

  // ------------------------------------------------------------
  // registers and state
  // ------------------------------------------------------------
  logic [7:0]      ie_r, ie2_r, ip_r, ip2_r, spctl_r, counter_mode_r;
  logic [7:0]      cm0_r, cm1_r;
  logic            xfer_done_flag_r, write_clash_flag_r, cf_r;
  logic [1:0]      ccf_r;
  logic [NSRC-1:0] samp_r;
  logic            hold_r;
  logic [4:0]      last_num_r;
  logic            ss_m_r, ss_s_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0]     wdata_r;
  logic            wstrb0_r;
  logic            aw_full_r, w_full_r;

  // ------------------------------------------------------------
  // axi4-lite write path
  // ------------------------------------------------------------
  // address and data may arrive in either order; one write at a time
  wire       wr_go   = aw_full_r & w_full_r & ~s_axi_bvalid;
  wire [7:0] wr_ix   = awaddr_r[9:2];
  wire       wr_hit  = (awaddr_r[ADDR_W-1:10] == '0) & (awaddr_r[1:0] == 2'b00);
  wire       wr_en   = wr_go & wstrb0_r & wr_hit;
  wire [7:0] wd      = wdata_r[7:0];
  wire       wr_map  = wr_hit & (wr_ix == IX_IE  | wr_ix == IX_IE2 |
                                 wr_ix == IX_IP  | wr_ix == IX_IP2 |
                                 wr_ix == IX_SPS | wr_ix == IX_SPCTL |
                                 wr_ix == IX_COUNTER_CTRL_REG | wr_ix == IX_COUNTER_MODE |
                                 wr_ix == IX_CM0 | wr_ix == IX_CM1 |
                                 wr_ix == IX_STAT);
  wire       w_ie    = wr_en & (wr_ix == IX_IE);
  wire       w_ie2   = wr_en & (wr_ix == IX_IE2);
  wire       w_ip    = wr_en & (wr_ix == IX_IP);
  wire       w_ip2   = wr_en & (wr_ix == IX_IP2);
  wire       w_sps   = wr_en & (wr_ix == IX_SPS);
  wire       w_counter_ctrl_reg  = wr_en & (wr_ix == IX_COUNTER_CTRL_REG);
  wire       w_cfg   = w_ie | w_ie2 | w_ip | w_ip2;

  // capture address and data channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb0_r  <= 1'b0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_full_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_full_r <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_full_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb0_r <= s_axi_wstrb[0];
      end else if (wr_go) begin
        w_full_r <= 1'b0;
      end
    end
  end

  // write response; unmapped addresses answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ready only while the holding slot is empty
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_full_r & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~w_full_r & ~(s_axi_wvalid & s_axi_wready);
    end
  end

  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  // plain control registers; counter_mode/module modes keep all bits for software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ie_r    <= REG_RST;
      ie2_r   <= REG_RST;
      ip_r    <= REG_RST;
      ip2_r   <= REG_RST;
      spctl_r <= REG_RST;
      counter_mode_r  <= REG_RST;
      cm0_r   <= REG_RST;
      cm1_r   <= REG_RST;
    end else begin
      if (w_ie)  ie_r  <= wd;
      if (w_ie2) ie2_r <= wd;
      if (w_ip)  ip_r  <= wd;
      if (w_ip2) ip2_r <= wd;
      if (wr_en & (wr_ix == IX_SPCTL)) spctl_r <= wd;
      if (wr_en & (wr_ix == IX_COUNTER_MODE))  counter_mode_r  <= wd;
      if (wr_en & (wr_ix == IX_CM0))   cm0_r   <= wd;
      if (wr_en & (wr_ix == IX_CM1))   cm1_r   <= wd;
    end
  end

  // ------------------------------------------------------------
  // serial interface flags
  // ------------------------------------------------------------
  // select pin is asynchronous: two flops before any use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ss_m_r <= 1'b1;
      ss_s_r <= 1'b1;
    end else begin
      ss_m_r <= ss_pin;
      ss_s_r <= ss_m_r;
    end
  end

  wire mode_chg = spi_master & ~spctl_r[B_SELECT_IGNORE] & ss_is_input & ~ss_s_r;
  wire xfer_done_flag_set = spi_done | mode_chg;
  wire write_clash_flag_set = serial_data_reg_wr & spi_busy;

  // write-one clears; a set in the same cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xfer_done_flag_r <= 1'b0;
      write_clash_flag_r <= 1'b0;
    end else begin
      xfer_done_flag_r <= xfer_done_flag_set | (xfer_done_flag_r & ~(w_sps & wd[B_XFER_DONE_FLAG]));
      write_clash_flag_r <= write_clash_flag_set | (write_clash_flag_r & ~(w_sps & wd[B_WRITE_CLASH_FLAG]));
    end
  end

  // ------------------------------------------------------------
  // counter array flags
  // ------------------------------------------------------------
  // match sets the event flag only when the module's match enable is on
  wire [1:0] ccf_set = (cmp_hit & {cm1_r[B_MAT], cm0_r[B_MAT]}) | cap_evt;

  // wrap flag may be written either way; event flags clear only; set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cf_r  <= 1'b0;
      ccf_r <= 2'b00;
    end else begin
      cf_r  <= cnt_wrap | (w_counter_ctrl_reg ? wd[B_CF] : cf_r);
      ccf_r <= ccf_set | (ccf_r & ~(w_counter_ctrl_reg ? ~wd[1:0] : 2'b00));
    end
  end

  // ------------------------------------------------------------
  // request gating
  // ------------------------------------------------------------
  wire pca_req = (cf_r & counter_mode_r[B_ECF])
               | (ccf_r[0] & cm0_r[B_ECCF])
               | (ccf_r[1] & cm1_r[B_ECCF]);
  wire spi_req = xfer_done_flag_r & ie2_r[B_SERIAL_PERIPH_IRQ_EN];

  logic [NSRC-1:0] raw, src_en, pend, hi_sel;
  // per-source enables; sources above 9 arrive already gated by their owners
  always_comb begin
    raw          = src_req;
    raw[SRC_PCA] = pca_req;
    raw[SRC_SPI] = spi_req;
    src_en       = ~SRC_UNUSED;
    src_en[N_IE_SRC-1:0] = ie_r[N_IE_SRC-1:0];
    src_en[SRC_S2]       = ie2_r[B_ES2];
    hi_sel          = '0;
    hi_sel[7:0]     = ip_r;
    hi_sel[SRC_S2]  = ip2_r[0];
    hi_sel[SRC_SPI] = ip2_r[1];
    hi_sel[SRC_PWM] = ip2_r[2];
    hi_sel[SRC_PFD] = ip2_r[3];
    hi_sel[SRC_X4]  = ip2_r[4];
    pend = ie_r[B_EA] ? (raw & src_en) : '0;
  end

  // ------------------------------------------------------------
  // sampling, polling and arbitration
  // ------------------------------------------------------------
  // polled set: sampled at last fetch and still active now
  // a high request sampled early is called at the next final-cycle poll
  wire [NSRC-1:0] poll    = samp_r & pend;
  wire [NSRC-1:0] poll_hi = poll & hi_sel;
  wire [NSRC-1:0] poll_lo = poll & ~hi_sel;
  wire            ok_hi   = ~in_prog_r[1];
  wire            ok_lo   = ~in_prog_r[1] & ~in_prog_r[0];
  wire            take_hi = ok_hi & (poll_hi != '0);
  wire            take_lo = ok_lo & (poll_lo != '0) & ~take_hi;
  wire            blocked = ~last_cycle | instr_return_from_irq | instr_cfg_wr
                          | isp_active | hold_r;
  wire            go      = opfetch & ~blocked & (take_hi | take_lo);
  wire [4:0]      win     = take_hi ? pick(poll_hi) : pick(poll_lo);
  wire [15:0]     vec     = VEC_BASE + ({11'h000, win} << VEC_SHIFT);

  // samples refresh every fetch, so a denied request is simply dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      samp_r <= '0;
    end else if (opfetch) begin
      samp_r <= pend;
    end
  end

  // a config write over the bus holds off the next poll
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_r <= 1'b0;
    end else if (w_cfg) begin
      hold_r <= 1'b1;
    end else if (opfetch & last_cycle) begin
      hold_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // call issue and level tracking
  // ------------------------------------------------------------
  // core pushes the program counter only and jumps to call_vec_r
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      call_r     <= 1'b0;
      call_vec_r <= '0;
      call_num_r <= '0;
      last_num_r <= '0;
      ext_clr_r  <= 2'b00;
    end else begin
      call_r    <= go;
      ext_clr_r <= {go & (win == 5'(SRC_X1)) & ext_edge[1],
                    go & (win == 5'(SRC_X0)) & ext_edge[0]};
      if (go) begin
        call_vec_r <= vec;
        call_num_r <= win;
        last_num_r <= win;
      end
    end
  end

  // return clears the high bit first; plain return is never seen here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_prog_r <= 2'b00;
    end else if (go) begin
      in_prog_r <= in_prog_r | {take_hi, take_lo};
    end else if (instr_return_from_irq & last_cycle) begin
      in_prog_r <= in_prog_r[1] ? {1'b0, in_prog_r[0]} : 2'b00;
    end
  end

  // serial request level for observers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xfer_irq_r <= 1'b0;
    end else begin
      xfer_irq_r <= spi_req & ie_r[B_EA];
    end
  end

  // ------------------------------------------------------------
  // axi4-lite read path
  // ------------------------------------------------------------
  wire [7:0] rd_ix  = s_axi_araddr[9:2];
  wire       rd_hit = (s_axi_araddr[ADDR_W-1:10] == '0) & (s_axi_araddr[1:0] == 2'b00);
  logic [7:0] rd_val;
  logic       rd_ok;
  // read mux; unmapped indices return zero with slverr
  always_comb begin
    rd_ok  = rd_hit;
    rd_val = 8'h00;
    unique case (rd_ix)
      IX_IE:    rd_val = ie_r;
      IX_IE2:   rd_val = ie2_r;
      IX_IP:    rd_val = ip_r;
      IX_IP2:   rd_val = ip2_r;
      IX_SPS:   rd_val = {xfer_done_flag_r, write_clash_flag_r, 6'h00};
      IX_SPCTL: rd_val = spctl_r;
      IX_COUNTER_CTRL_REG:  rd_val = {cf_r, 5'h00, ccf_r};
      IX_COUNTER_MODE:  rd_val = counter_mode_r;
      IX_CM0:   rd_val = cm0_r;
      IX_CM1:   rd_val = cm1_r;
      IX_STAT:  rd_val = {in_prog_r, 1'b0, last_num_r};
      default:  rd_ok  = 1'b0;
    endcase
  end

  // single-beat read, answer one cycle after address accepted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_ok ? rd_val : 8'h00};
        s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // pic_top

// >>> tb/pic_chk.sv
// pic_chk: call, level and clear checks on pic_top ports.
// assumes binding into every pic_top instance.
`timescale 1ns/1ps
module pic_chk
  import pic_pkg::*;
(
  input wire logic        aclk,         // clock
  input wire logic        aresetn,      // reset, low
  input wire logic        opfetch,      // fetch
  input wire logic        last_cycle,   // final clock
  input wire logic        instr_return_from_irq,   // return
  input wire logic        instr_cfg_wr, // cfg write
  input wire logic        isp_active,   // programming
  input wire logic        call_r,       // call pulse
  input wire logic [15:0] call_vec_r,   // vector
  input wire logic [4:0]  call_num_r,   // number
  input wire logic [1:0]  ext_clr_r,    // ext clear
  input wire logic [1:0]  in_prog_r     // levels
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_vec; call_r |-> call_vec_r == VEC_BASE + {8'h00, call_num_r, 3'b000} && !SRC_UNUSED[call_num_r]; endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_blk; call_r |-> $past(opfetch && last_cycle && !instr_return_from_irq && !instr_cfg_wr && !isp_active); endproperty
  a_blk: assert property (p_blk) else $error("call while blocked");
  property p_inp; call_r |-> in_prog_r != $past(in_prog_r); endproperty
  a_inp: assert property (p_inp) else $error("level not marked");
  property p_hi; call_r |-> !$past(in_prog_r[1]); endproperty
  a_hi: assert property (p_hi) else $error("high routine preempted");
  property p_lo; call_r && $past(in_prog_r[0]) |-> in_prog_r[1] && !$past(in_prog_r[1]); endproperty
  a_lo: assert property (p_lo) else $error("low preempted low");
  property p_ret; instr_return_from_irq && last_cycle && in_prog_r[1] |=> in_prog_r == {1'b0, $past(in_prog_r[0])}; endproperty
  a_ret: assert property (p_ret) else $error("high level not ended first");
  property p_ret0; instr_return_from_irq && last_cycle && in_prog_r == 2'b01 |=> in_prog_r == 2'b00; endproperty
  a_ret0: assert property (p_ret0) else $error("level not ended");
  property p_clr; ext_clr_r != 2'b00 |-> call_r && $onehot(ext_clr_r) && call_num_r == (ext_clr_r[0] ? 5'd0 : 5'd2); endproperty
  a_clr: assert property (p_clr) else $error("bad ext clear");
  c_spi: cover property (call_r && call_num_r == 5'd9);
  c_clr: cover property (ext_clr_r[0]);
  c_ret: cover property (instr_return_from_irq && last_cycle && in_prog_r == 2'b10);
endmodule // pic_chk
bind pic_top pic_chk u_pic_chk (.aclk, .aresetn, .opfetch, .last_cycle, .instr_return_from_irq, .instr_cfg_wr,
  .isp_active, .call_r, .call_vec_r, .call_num_r, .ext_clr_r, .in_prog_r);

// >>> tb/pic_core_model.sv
// pic_core_model: behavioural core driving fetch, last-cycle and return flags.
// assumes cmd pulses come from the bench one cycle long.
`timescale 1ns/1ps
module pic_core_model (
  input  wire logic       aclk,         // clock
  input  wire logic       aresetn,      // sync reset, low
  input  wire logic [1:0] cmd,          // {cfg write, return} request
  output logic            opfetch,      // fetch cycle
  output logic            last_cycle,   // final clock
  output logic            instr_return_from_irq,   // return instruction
  output logic            instr_cfg_wr  // enable/priority write
);
  logic [1:0] ph_r;
  logic [1:0] pend_r;
  // instruction mix: one single-cycle, then one two-cycle instruction
  always_ff @(posedge aclk) begin
    if (!aresetn) ph_r <= 2'h0;
    else ph_r <= (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
  end
  assign opfetch    = (ph_r != 2'h2);
  assign last_cycle = (ph_r != 2'h1);
  // requested instruction lasts until its final clock ends
  always_ff @(posedge aclk) begin
    if (!aresetn) pend_r <= 2'h0;
    else if (last_cycle) pend_r <= cmd;
    else pend_r <= pend_r | cmd;
  end
  assign instr_return_from_irq   = pend_r[0];
  assign instr_cfg_wr = pend_r[1];
endmodule // pic_core_model

// >>> tb/prioritized_interrupt_controller_bench.sv
// bench for pic_top: axi4-lite register tasks, core model, request stimulus.
// assumes pic_chk bound and pic_core_model compiled first.
`timescale 1ns/1ps
module prioritized_interrupt_controller_bench;
  import pic_pkg::*;
  logic aclk = 0, aresetn = 0, isp_active = 0, spi_done = 0, serial_data_reg_wr = 0, spi_busy = 0;
  logic spi_master = 0, ss_is_input = 0, ss_pin = 1;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, call_r, xfer_irq_r;
  logic opfetch, last_cycle, instr_return_from_irq, instr_cfg_wr;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, ext_clr_r, in_prog_r, clr_seen, ext_edge = 0, cmd = 0, cmp_hit = 0;
  logic [NSRC-1:0] src_req = 0;
  logic [15:0] call_vec_r;
  logic [4:0] call_num_r;
  int miscompares = 0, n_tests = 0;
  pic_top u_pic_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .opfetch, .last_cycle, .instr_return_from_irq,
    .instr_cfg_wr, .isp_active, .src_req, .ext_edge, .spi_done, .spi_master, .ss_is_input,
    .ss_pin, .serial_data_reg_wr, .spi_busy, .cnt_wrap(1'b0), .cmp_hit, .cap_evt(2'b00), .call_r, .call_vec_r,
    .call_num_r, .ext_clr_r, .in_prog_r, .xfer_irq_r);
  pic_core_model u_pic_core_model (.aclk, .aresetn, .cmd, .opfetch, .last_cycle, .instr_return_from_irq, .instr_cfg_wr);
  // clock, then ten cycles of reset
  initial forever #5 aclk = ~aclk;
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
  end
  task automatic chk(input logic [39:0] got, exp, input string m);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  // axi write: both channels offered together, each dropped once taken
  task automatic wr(input logic [7:0] ix, d, input logic [1:0] er = RESP_OKAY);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= {2'b00, ix, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    chk({s_axi_bvalid, s_axi_bresp}, {1'b1, er}, "write response");
  endtask
  task automatic rd(input logic [7:0] ix, exp, input logic [1:0] er = RESP_OKAY);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= {2'b00, ix, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_rready <= 1'b0;
    chk({s_axi_rvalid, s_axi_rresp, s_axi_rdata}, {1'b1, er, 24'h0, exp}, "read data");
  endtask
  // bounded wait for the call pulse, then its number and vector
  task automatic wait_call(input logic [4:0] num);
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (call_r !== 1'b1 && n < 40);
    clr_seen = ext_clr_r;
    chk({call_r, call_num_r, call_vec_r}, {1'b1, num, VEC_BASE + (16'(num) << VEC_SHIFT)}, "call");
  endtask
  task automatic no_call(input int n);
    repeat (n) begin
      @(posedge aclk);
      chk(call_r, 1'b0, "unexpected call");
    end
  endtask
  // return: wait only until the return instruction ends, so a following call is not missed
  task automatic return_from_irq();
    @(posedge aclk);
    cmd <= 2'b01;
    @(posedge aclk);
    cmd <= 2'b00;
    do begin
      @(posedge aclk);
    end while (instr_return_from_irq === 1'b1);
  endtask
  // one-cycle pulse: 0 transfer done, 1 data write, else module 0 match
  task automatic pulse(input int k);
    @(posedge aclk);
    if (k == 0) spi_done <= 1'b1;
    else if (k == 1) serial_data_reg_wr <= 1'b1;
    else cmp_hit[0] <= 1'b1;
    @(posedge aclk);
    spi_done <= 1'b0;
    serial_data_reg_wr <= 1'b0;
    cmp_hit[0] <= 1'b0;
  endtask
  task automatic t_regs();
    rd(IX_COUNTER_MODE, REG_RST);
    wr(IX_CM1, 8'h09);
    rd(IX_CM1, 8'h09);
    rd(8'h10, 8'h00, RESP_SLVERR);
    wr(8'h10, 8'hff, RESP_SLVERR);
  endtask
  task automatic t_ea();
    wr(IX_IE, 8'h02);
    src_req[1] <= 1'b1;
    no_call(15);
    wr(IX_IE, 8'h82);
    wait_call(5'd1);
    src_req <= '0;
    return_from_irq();
  endtask
  // high beats low, ties go to the lowest number, no low-on-low nesting
  task automatic t_prio();
    wr(IX_IE, 8'h9a);
    wr(IX_IP, 8'h10);
    src_req <= 24'h00001a;
    wait_call(5'd4);
    chk(in_prog_r, 2'b10, "high in progress");
    no_call(12);
    src_req[4] <= 1'b0;
    return_from_irq();
    wait_call(5'd1);
    no_call(12);
    src_req[1] <= 1'b0;
    return_from_irq();
    wait_call(5'd3);
    src_req <= '0;
    return_from_irq();
    chk(in_prog_r, 2'b00, "levels ended");
  endtask
  task automatic t_spi();
    wr(IX_IE, 8'h80);
    wr(IX_IE2, 8'h02);
    pulse(0);
    wait_call(5'(SRC_SPI));
    chk(xfer_irq_r, 1'b1, "serial request");
    rd(IX_SPS, 8'h80);
    wr(IX_SPS, 8'h80);
    rd(IX_SPS, 8'h00);
    spi_busy <= 1'b1;
    pulse(1);
    rd(IX_SPS, 8'h40);
    wr(IX_SPS, 8'h40);
    rd(IX_SPS, 8'h00);
    spi_busy <= 1'b0;
    spi_master <= 1'b1;
    ss_is_input <= 1'b1;
    ss_pin <= 1'b0;
    repeat (4) @(posedge aclk);
    ss_pin <= 1'b1;
    spi_master <= 1'b0;
    ss_is_input <= 1'b0;
    rd(IX_SPS, 8'h80);
    wr(IX_SPS, 8'h80);
    return_from_irq();
  endtask
  task automatic t_pca();
    wr(IX_COUNTER_MODE, 8'h01);
    wr(IX_COUNTER_CTRL_REG, 8'h80);
    wait_call(5'(SRC_PCA));
    wr(IX_COUNTER_CTRL_REG, 8'h00);
    return_from_irq();
    wr(IX_CM0, 8'h09);
    pulse(2);
    wait_call(5'(SRC_PCA));
    rd(IX_COUNTER_CTRL_REG, 8'h01);
    wr(IX_COUNTER_CTRL_REG, 8'h00);
    return_from_irq();
  endtask
  task automatic t_ext();
    wr(IX_IE, 8'h81);
    ext_edge <= 2'b01;
    src_req[0] <= 1'b1;
    wait_call(5'd0);
    chk(clr_seen, 2'b01, "edge flag cleared");
    src_req <= '0;
    return_from_irq();
  endtask
  // request seen only while programming blocks it is dropped
  task automatic t_blk();
    wr(IX_IE, 8'h82);
    isp_active <= 1'b1;
    src_req[1] <= 1'b1;
    no_call(9);
    src_req <= '0;
    isp_active <= 1'b0;
    no_call(12);
    rd(IX_IE, 8'h82);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    t_regs();
    t_ea();
    t_prio();
    t_spi();
    t_pca();
    t_ext();
    t_blk();
    finish_test();
  end
  // watchdog well past the expected few hundred cycles
  initial begin
    #300000;
    miscompares++;
    finish_test();
  end
endmodule // prioritized_interrupt_controller_bench
